//--- bench/osbc_osc_model.sv
// Behavioural oscillator cells and program strap source facing the block
`timescale 1ns/1ps
`default_nettype none
module osbc_osc_model (
  // Enables from the block
  input  wire logic crystal_en,
  input  wire logic fast_rc_en,
  input  wire logic slow_rc_en,
  // High only during the programming pass
  input  wire logic program_run,
  // Oscillator levels and trim strap
  output logic      crystal_osc,
  output logic      fast_rc_osc,
  output logic      slow_rc_osc,
  output logic      trim_directive
);
  // Half periods in ns; the 3 ns start offset keeps edges clear of clock edges
  localparam int XTAL_HALF = 55;  // Crystal, 11 clocks a period
  localparam int FAST_HALF = 45;  // Fast RC, 9 clocks a period
  localparam int SLOW_HALF = 65;  // Slow RC, 13 clocks a period

  // Trim directive only while the programmer runs; later boots go without
  assign trim_directive = program_run;

  // Crystal cell: a disabled cell rests low instead of freezing mid-cycle
  initial
  begin
    crystal_osc = 1'b0;
    #3;
    forever #XTAL_HALF crystal_osc = (crystal_en === 1'b1) ? ~crystal_osc : 1'b0;
  end

  // Fast RC cell
  initial
  begin
    fast_rc_osc = 1'b0;
    #3;
    forever #FAST_HALF fast_rc_osc = (fast_rc_en === 1'b1) ? ~fast_rc_osc : 1'b0;
  end

  // Slow RC cell, also the boot wait time base
  initial
  begin
    slow_rc_osc = 1'b0;
    #3;
    forever #SLOW_HALF slow_rc_osc = (slow_rc_en === 1'b1) ? ~slow_rc_osc : 1'b0;
  end
endmodule : osbc_osc_model
`default_nettype wire

//--- bench/osc_select_boot_ctrl_tb_top.sv
// Self-checking bench for the oscillator select and boot control block
`timescale 1ns/1ps
`default_nettype none
module osc_select_boot_ctrl_tb_top;
  // Clock, reset and register port
  logic       clk;
  logic       sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  // Straps and programming pass
  logic       program_run;
  logic [2:0] trim_div_sel;
  logic [4:0] trim_target_mhz;
  logic [7:0] trim_code;
  // Oscillator side and core side
  logic       crystal_osc, fast_rc_osc, slow_rc_osc, trim_directive;
  logic       crystal_en, fast_rc_en, slow_rc_en, bandgap_en;
  logic [1:0] crystal_drive;
  logic [7:0] fast_rc_trim;
  logic       cpu_run, pc_load, sys_tick;
  logic [9:0] pc_start;
  logic [1:0] system_clock_choice;
  // Scoreboard
  int         n_fail;
  int         num_checks;
  logic [7:0] rd_val;
  int         rises;
  // Mode codes, source index, divide and source code for the switch table
  logic [7:0] codes [7] = '{8'he4, 8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'hb4};
  int         srcs  [7] = '{0, 1, 1, 1, 1, 1, 2};
  int         pers  [7] = '{1, 2, 4, 8, 16, 32, 1};
  logic [1:0] chs   [7] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3};

  osbc_ctrl osbc_ctrl_i (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .crystal_osc(crystal_osc), .fast_rc_osc(fast_rc_osc), .slow_rc_osc(slow_rc_osc),
    .trim_directive(trim_directive), .trim_div_sel(trim_div_sel),
    .trim_target_mhz(trim_target_mhz), .trim_code(trim_code),
    .crystal_en(crystal_en), .crystal_drive(crystal_drive), .fast_rc_en(fast_rc_en),
    .slow_rc_en(slow_rc_en), .fast_rc_trim(fast_rc_trim), .bandgap_en(bandgap_en),
    .cpu_run(cpu_run), .pc_load(pc_load), .pc_start(pc_start), .sys_tick(sys_tick),
    .system_clock_choice(system_clock_choice));

  osbc_osc_model osbc_osc_model_i (
    .crystal_en(crystal_en), .fast_rc_en(fast_rc_en), .slow_rc_en(slow_rc_en),
    .program_run(program_run), .crystal_osc(crystal_osc), .fast_rc_osc(fast_rc_osc),
    .slow_rc_osc(slow_rc_osc), .trim_directive(trim_directive));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Verdict, reached from the main sequence and from any expired wait
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // Compare with case inequality so an unknown never matches
  task automatic check(input logic [10:0] got, input logic [10:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // Expired wait counts as a mismatch and closes the run
  task automatic hang(input string what);
    n_fail++;
    $display("wrong value at %0t: %s never came", $time, what);
    end_of_test();
  endtask : hang

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // One-cycle read strobe; data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  function automatic logic osc(input int s);
    return (s == 0) ? slow_rc_osc : (s == 1) ? fast_rc_osc : crystal_osc;
  endfunction : osc

  task automatic wait_tick();
    for (int g = 0; g < 4000; g++)
    begin
      @(posedge clk);
      #1;
      if (sys_tick === 1'b1)
        return;
    end
    hang("system tick");
  endtask : wait_tick

  // Source rises between two settled ticks; the first tick may be a handover
  task automatic span(input int s, output int n);
    logic p;
    wait_tick();
    wait_tick();
    p = osc(s);
    n = 0;
    for (int g = 0; g < 4000; g++)
    begin
      @(posedge clk);
      #1;
      if (osc(s) && !p)
        n++;
      p = osc(s);
      if (sys_tick === 1'b1)
        return;
    end
    hang("tick span");
  endtask : span

  // Reset, count slow RC rises until release, then check the loaded state
  task automatic boot(input logic dir, input logic [2:0] sel, input logic [4:0] mhz,
                      input logic [7:0] code, input logic [7:0] mode,
                      input logic [7:0] trim, input int src, input int per);
    logic p;
    int   n;
    @(posedge clk);
    program_run     <= dir;
    trim_div_sel    <= sel;
    trim_target_mhz <= mhz;
    trim_code       <= code;
    sys_rst         <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check(cpu_run, 1'b0, "held core");
    p = 1'b0;
    n = 0;
    for (int g = 0; g < 16000 && cpu_run !== 1'b1; g++)
    begin
      @(posedge clk);
      #1;
      if (slow_rc_osc && !p)
        n++;
      p = slow_rc_osc;
    end
    if (cpu_run !== 1'b1)
      hang("core release");
    check(11'(n), 11'd1024, "boot wait rises");
    check(pc_load, 1'b1, "start load");
    check(pc_start, 10'h000, "start address");
    check({crystal_en, slow_rc_en}, 2'b01, "oscillators after boot");
    check(fast_rc_en, mode[4], "fast enable");
    check(bandgap_en, dir, "bandgap");
    check(fast_rc_trim, trim, "trim output");
    rd(osbc_pkg::ADDR_MODE, rd_val);
    check(rd_val, mode, "mode after boot");
    rd(osbc_pkg::ADDR_TRIM, rd_val);
    check(rd_val, trim, "trim after boot");
    rd(osbc_pkg::ADDR_STATUS, rd_val);
    check({rd_val[7], rd_val[5:4]}, {1'b1, dir, 1'b0}, "status after boot");
    span(src, n);
    check(11'(n), 11'(per), "boot clock divide");
  endtask : boot

  // Main sequence
  initial
  begin
    n_fail = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    program_run = 1'b0;
    trim_div_sel = 3'h0;
    trim_target_mhz = 5'h10;
    trim_code = 8'h00;
    boot(1'b1, osbc_pkg::TDIV_D4, 5'h10, 8'h5a, 8'h14, 8'h5a, 1, 4);
    boot(1'b1, osbc_pkg::TDIV_D32, 5'h12, 8'h3c, 8'h7c, 8'h3c, 1, 32);
    boot(1'b1, osbc_pkg::TDIV_SLOW, 5'h11, 8'hc3, 8'he4, 8'hc3, 0, 1);
    boot(1'b0, osbc_pkg::TDIV_D2, 5'h10, 8'h11, 8'hf4, 8'h80, 0, 1);
    // Unmapped and crystal register
    rd(8'h7f, rd_val);
    check(rd_val, 8'h00, "unmapped read");
    rd(osbc_pkg::ADDR_XTAL, rd_val);
    check(rd_val, 8'h00, "crystal reset");
    wr(osbc_pkg::ADDR_XTAL, 8'he0);
    #1;
    check({crystal_en, crystal_drive, fast_rc_en, slow_rc_en}, 5'h1f, "enables");
    // Software trim write reaches the fast RC cell
    wr(osbc_pkg::ADDR_TRIM, 8'ha5);
    #1;
    check(fast_rc_trim, 8'ha5, "trim write");
    rd(osbc_pkg::ADDR_TRIM, rd_val);
    check(rd_val, 8'ha5, "trim readback");
    // Walk every source code; old source stays on across each switch
    for (int i = 0; i < 7; i++)
    begin
      wr(osbc_pkg::ADDR_MODE, codes[i]);
      rd(osbc_pkg::ADDR_STATUS, rd_val);
      check(rd_val[3:2], chs[i], "requested source");
      check(fast_rc_en, codes[i][4], "fast enable follows mode");
      span(srcs[i], rises);
      check(11'(rises), 11'(pers[i]), "divide");
      check(system_clock_choice, chs[i], "active source");
    end
    // Old fast oscillator turned off only in a later write
    wr(osbc_pkg::ADDR_MODE, 8'ha4);
    #1;
    check(fast_rc_en, 1'b0, "fast off");
    span(2, rises);
    check(11'(rises), 11'd1, "crystal still clocks");
    end_of_test();
  end
endmodule : osc_select_boot_ctrl_tb_top
`default_nettype wire

//--- hdl/osbc_ctrl.sv
// Oscillator select, divider, boot wait and trim load for the core
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R01: Hold core for 1024 slow RC cycles
// R02: Core starts fetching at address zero
// R03: Three independent oscillator enable bits
// R04: After boot both RC on, crystal off; fast RC is off when the trim step loads E4h
// R05: Writable trim register adjusts fast RC
// R06: Trim step supports five dividers, 16-18 MHz
// R07: Codes 34h, 14h, 3Ch pick fast /2,/4,/8
// R08: Codes 1Ch, 7Ch pick fast /16,/32
// R09: Code E4h picks slow RC, fast off
// R10: No trim step: registers kept, bandgap off
// R11: Trim step runs once, at programming
// R12: Software may pick any of three sources
// R13: Mode write switches clock at once; code switches at the end of the current divided period
// R14: Old oscillator off only in later write
// R15: Source change free of runt ticks
module osbc_ctrl (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Oscillator levels from the analog cells
  input  wire logic       crystal_osc,
  input  wire logic       fast_rc_osc,
  input  wire logic       slow_rc_osc,
  // Trim directive straps from program memory
  input  wire logic       trim_directive,
  input  wire logic [2:0] trim_div_sel,
  input  wire logic [4:0] trim_target_mhz,
  input  wire logic [7:0] trim_code,
  // Oscillator controls
  output logic            crystal_en,
  output logic      [1:0] crystal_drive,
  output logic            fast_rc_en,
  output logic            slow_rc_en,
  output logic      [7:0] fast_rc_trim,
  output logic            bandgap_en,
  // Core side
  output logic            cpu_run,
  output logic            pc_load,
  output logic      [9:0] pc_start,
  output logic            sys_tick,
  output logic      [1:0] system_clock_choice
);

  // Registers
  logic [7:0]  mode_ff;       // Clock mode register
  logic [7:0]  xtal_ff;       // Crystal control register
  logic [7:0]  trim_ff;       // Fast RC trim register
  logic        bandgap_ff;    // Band-gap switch
  logic        trim_done_ff;  // Trim step applied at boot
  logic        trim_bad_ff;   // Trim straps out of range
  logic [10:0] boot_cnt_ff;   // Slow RC cycles counted
  logic        run_ff;        // Core released
  logic        pc_load_ff;    // Start-address load pulse
  logic [9:0]  pc_ff;         // Start address
  logic [4:0]  div_cnt_ff;    // Divider position
  logic [2:0]  cur_exp_ff;    // Active divide exponent
  logic        tick_ff;       // System clock enable pulse
  logic [7:0]  rdata_ff;      // Read data, one cycle only
  osbc_pkg::osbc_src_t  cur_src_ff;  // Active source
  osbc_pkg::osbc_boot_t boot_ff;     // Boot phase

  // Synchronised oscillator edges; filtered levels are not needed here
  logic xtal_rise;
  logic fast_rise;
  logic slow_rise;

  // One synchroniser per oscillator input
  osbc_edge_sync u_sync_xtal (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .osc_in   (crystal_osc),
    .level_ff (),
    .rise_ff  (xtal_rise)
  );
  osbc_edge_sync u_sync_fast (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .osc_in   (fast_rc_osc),
    .level_ff (),
    .rise_ff  (fast_rise)
  );
  osbc_edge_sync u_sync_slow (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .osc_in   (slow_rc_osc),
    .level_ff (),
    .rise_ff  (slow_rise)
  );

  // Register decode
  wire wr_mode = reg_wr & (reg_addr == osbc_pkg::ADDR_MODE);
  wire wr_xtal = reg_wr & (reg_addr == osbc_pkg::ADDR_XTAL);
  wire wr_trim = reg_wr & (reg_addr == osbc_pkg::ADDR_TRIM);

  // Mode selector key; unknown keys fall back to slow RC undivided
  wire [3:0] sel_key = {mode_ff[7:5], mode_ff[3]};
  wire       key_fast = (sel_key == osbc_pkg::KEY_FAST_D2)  |
                        (sel_key == osbc_pkg::KEY_FAST_D4)  |
                        (sel_key == osbc_pkg::KEY_FAST_D8)  |
                        (sel_key == osbc_pkg::KEY_FAST_D16) |
                        (sel_key == osbc_pkg::KEY_FAST_D32);
  // Requested source, taken from the mode register right after a write
  wire [1:0] sel_src =                                            // R12
    key_fast                              ? osbc_pkg::SRC_FAST :
    (sel_key == osbc_pkg::KEY_XTAL_D1)    ? osbc_pkg::SRC_XTAL :
                                            osbc_pkg::SRC_SLOW;
  // Requested divide exponent
  wire [2:0] sel_exp =                                            // R07
    (sel_key == osbc_pkg::KEY_FAST_D2)  ? 3'h1 :
    (sel_key == osbc_pkg::KEY_FAST_D4)  ? 3'h2 :
    (sel_key == osbc_pkg::KEY_FAST_D8)  ? 3'h3 :
    (sel_key == osbc_pkg::KEY_FAST_D16) ? 3'h4 :                 // R08
    (sel_key == osbc_pkg::KEY_FAST_D32) ? 3'h5 : 3'h0;

  // Divider against the active source
  wire [4:0] div_last = 5'((6'h01 << cur_exp_ff) - 6'h01);
  wire       cur_rise = (cur_src_ff == osbc_pkg::SRC_FAST) ? fast_rise :
                        (cur_src_ff == osbc_pkg::SRC_XTAL) ? xtal_rise : slow_rise;
  wire       period_end = cur_rise & (div_cnt_ff == div_last);
  wire       switch_pend = (cur_src_ff != sel_src) | (cur_exp_ff != sel_exp);

  // Trim step decode at boot end
  wire       target_ok  = (trim_target_mhz >= osbc_pkg::TRIM_MHZ_MIN) &
                          (trim_target_mhz <= osbc_pkg::TRIM_MHZ_MAX);
  wire       div_ok     = (trim_div_sel <= osbc_pkg::TDIV_SLOW);
  wire [7:0] trim_mode  =                                         // R06
    (trim_div_sel == osbc_pkg::TDIV_D2)  ? osbc_pkg::MODE_FAST_D2  :
    (trim_div_sel == osbc_pkg::TDIV_D4)  ? osbc_pkg::MODE_FAST_D4  :
    (trim_div_sel == osbc_pkg::TDIV_D8)  ? osbc_pkg::MODE_FAST_D8  :
    (trim_div_sel == osbc_pkg::TDIV_D16) ? osbc_pkg::MODE_FAST_D16 :
    (trim_div_sel == osbc_pkg::TDIV_D32) ? osbc_pkg::MODE_FAST_D32 :
                                           osbc_pkg::MODE_SLOW_D1;
  wire       boot_end   = (boot_ff == osbc_pkg::BOOT_WAIT_ST) &
                          (boot_cnt_ff == osbc_pkg::BOOT_WAIT);
  // Directive is a strap, read once at release and never again
  wire       trim_apply = boot_end & trim_directive & target_ok & div_ok;

  // Read mux; unmapped offsets read zero
  wire [7:0] status_word = {run_ff, switch_pend, trim_done_ff, trim_bad_ff,
                            sel_src, cur_src_ff};
  wire [7:0] rd_mux =
    (reg_addr == osbc_pkg::ADDR_MODE)   ? mode_ff :
    (reg_addr == osbc_pkg::ADDR_XTAL)   ? xtal_ff :
    (reg_addr == osbc_pkg::ADDR_TRIM)   ? trim_ff :
    (reg_addr == osbc_pkg::ADDR_STATUS) ? status_word : 8'h00;

  // Boot phase: count slow RC rises, then release the core
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      boot_ff     <= osbc_pkg::BOOT_WAIT_ST;
      boot_cnt_ff <= 11'h000;
      run_ff      <= 1'b0;
    end
    else
    begin
      unique case (boot_ff)
        osbc_pkg::BOOT_WAIT_ST:
        begin
          // Supply may still settle; no fetch until the count is full
          if (boot_end)
          begin
            boot_ff <= osbc_pkg::BOOT_RUN_ST;                     // R01
            run_ff  <= 1'b1;
          end
          else if (slow_rise)
            boot_cnt_ff <= boot_cnt_ff + 11'h001;
        end
        // Only a reset returns to the wait
        osbc_pkg::BOOT_RUN_ST:
          run_ff <= 1'b1;
      endcase
    end
  end

  // Mode register; trim step overrides at release only
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      mode_ff <= osbc_pkg::MODE_RST;                              // R04
    else if (trim_apply)
      mode_ff <= trim_mode;                                       // R09
    else if (wr_mode)
      mode_ff <= reg_wdata;                                       // R13
  end

  // Crystal and trim registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      xtal_ff <= osbc_pkg::XTAL_RST;
      trim_ff <= osbc_pkg::TRIM_RST;
    end
    else
    begin
      // Crystal enable is separate from the RC enables
      if (wr_xtal)
        xtal_ff <= reg_wdata;                                     // R03
      if (trim_apply)
        trim_ff <= trim_code;                                     // R05
      else if (wr_trim)
        trim_ff <= reg_wdata;                                     // R05
    end
  end

  // Trim step outcome and band-gap
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bandgap_ff   <= 1'b0;                                       // R10
      trim_done_ff <= 1'b0;
      trim_bad_ff  <= 1'b0;
    end
    else if (boot_end)
    begin
      bandgap_ff   <= trim_apply;                                 // R10
      trim_done_ff <= trim_apply;
      trim_bad_ff  <= trim_directive & ~(target_ok & div_ok);
    end
  end

  // Divider and source handover; a change waits for the old period to
  // finish, then counts edges of the new source, so no short tick.
  // If the old oscillator is stopped first, the handover stalls.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cur_src_ff <= osbc_pkg::SRC_SLOW;
      cur_exp_ff <= 3'h0;
      div_cnt_ff <= 5'h00;
    end
    else if (period_end)
    begin
      cur_src_ff <= osbc_pkg::osbc_src_t'(sel_src);               // R15
      cur_exp_ff <= sel_exp;
      div_cnt_ff <= 5'h00;
    end
    else if (cur_rise)
      div_cnt_ff <= div_cnt_ff + 5'h01;
  end

  // Core pulses and read data; each stands for one cycle only
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pc_load_ff <= 1'b0;
      pc_ff      <= osbc_pkg::PC_RESET;
      tick_ff    <= 1'b0;
      rdata_ff   <= 8'h00;
    end
    else
    begin
      // Start address loads with release; ticks only after release
      pc_load_ff <= boot_end;                                     // R02
      pc_ff      <= osbc_pkg::PC_RESET;
      tick_ff    <= period_end & run_ff;                          // R15
      rdata_ff   <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata           = rdata_ff;
  assign crystal_en          = xtal_ff[osbc_pkg::XTAL_EN_BIT];
  assign crystal_drive       = xtal_ff[osbc_pkg::XTAL_DRV_HI:osbc_pkg::XTAL_DRV_LO];
  assign fast_rc_en          = mode_ff[osbc_pkg::MODE_FAST_EN];
  assign slow_rc_en          = mode_ff[osbc_pkg::MODE_SLOW_EN];
  assign fast_rc_trim        = trim_ff;
  assign bandgap_en          = bandgap_ff;
  assign cpu_run             = run_ff;
  assign pc_load             = pc_load_ff;
  assign pc_start            = pc_ff;
  assign sys_tick            = tick_ff;
  assign system_clock_choice = cur_src_ff;

  // Release only after the full slow RC count
  a_boot_release: assert property (@(posedge clk) disable iff (sys_rst) // R01
    $rose(run_ff) |-> $past(boot_cnt_ff) == osbc_pkg::BOOT_WAIT)
    else $error("core released before boot count");

  // Start address loaded as zero with release
  a_pc_zero_load: assert property (@(posedge clk) disable iff (sys_rst) // R02
    $rose(run_ff) |-> pc_load_ff && pc_ff == 10'h000 ##1 !pc_load_ff)
    else $error("start address not zero at release");

  // Oscillator state at release
  a_boot_osc_state: assert property (@(posedge clk) disable iff (sys_rst) // R04
    $rose(run_ff) |=> slow_rc_en && !crystal_en)
    else $error("oscillator state wrong after boot");

  // Crystal enable follows its own write only
  a_xtal_enable: assert property (@(posedge clk) disable iff (sys_rst) // R03
    wr_xtal |=> crystal_en == $past(reg_wdata[7]) && $stable(mode_ff))
    else $error("crystal enable not independent");

  // Trim register takes software value
  a_trim_write: assert property (@(posedge clk) disable iff (sys_rst) // R05
    (wr_trim && !trim_apply) |=> fast_rc_trim == $past(reg_wdata))
    else $error("trim write lost");

  // Fast /8 code decodes at once
  a_mode_fast8: assert property (@(posedge clk) disable iff (sys_rst) // R07
    (wr_mode && reg_wdata == 8'h3c) |=> sel_src == 2'b01 && sel_exp == 3'h3)
    else $error("fast /8 decode wrong");

  // Fast /32 code decodes at once
  a_mode_fast32: assert property (@(posedge clk) disable iff (sys_rst) // R08
    (wr_mode && reg_wdata == 8'h7c) |=> sel_src == 2'b01 && sel_exp == 3'h5)
    else $error("fast /32 decode wrong");

  // Slow code stops fast RC
  a_mode_slow: assert property (@(posedge clk) disable iff (sys_rst) // R09
    (wr_mode && reg_wdata == 8'he4) |=> !fast_rc_en && slow_rc_en && sel_src == 2'b00)
    else $error("slow code decode wrong");

  // No directive leaves band-gap off and mode register unchanged
  a_no_trim_step: assert property (@(posedge clk) disable iff (sys_rst) // R10
    (boot_end && !trim_directive) |=> !bandgap_en && mode_ff == $past(mode_ff))
    else $error("disabled trim step changed state");

  // Ticks only at the end of an active-source period
  a_tick_clean: assert property (@(posedge clk) disable iff (sys_rst) // R15
    sys_tick |-> $past(cur_rise) && $past(div_cnt_ff) == $past(div_last))
    else $error("runt tick on source change");

endmodule : osbc_ctrl
`default_nettype wire

//--- hdl/osbc_edge_sync.sv
// Three-stage synchroniser with agreement filter and rise detect
`timescale 1ns/1ps
`default_nettype none
module osbc_edge_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Asynchronous oscillator level
  input  wire logic osc_in,
  // Filtered level and one-cycle rise pulse
  output logic      level_ff,
  output logic      rise_ff
);

  logic s1_ff;  // First stage, read only by s2
  logic s2_ff;  // Second stage
  logic s3_ff;  // Third stage

  // A change counts only once stages two and three agree
  logic agree;
  assign agree = (s2_ff == s3_ff);

  // Shift chain
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= osc_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Filtered level and rise pulse
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      level_ff <= 1'b0;
      rise_ff  <= 1'b0;
    end
    else
    begin
      level_ff <= agree ? s3_ff : level_ff;
      rise_ff  <= agree & s3_ff & ~level_ff;
    end
  end

endmodule : osbc_edge_sync
`default_nettype wire

//--- hdl/osbc_pkg.sv
// Constants and types for the oscillator select and boot control block
package osbc_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_MODE     = 8'h03;  // Clock mode register
  localparam logic [7:0] ADDR_XTAL     = 8'h0b;  // Crystal control register
  localparam logic [7:0] ADDR_TRIM     = 8'h0c;  // Fast RC trim register
  localparam logic [7:0] ADDR_STATUS   = 8'h0d;  // Read-only status

  // Field positions
  localparam int XTAL_EN_BIT     = 7;          // Crystal enable
  localparam int XTAL_DRV_HI     = 6;          // Crystal drive field high bit
  localparam int XTAL_DRV_LO     = 5;          // Crystal drive field low bit
  localparam int MODE_FAST_EN    = 4;          // Fast RC enable
  localparam int MODE_SLOW_EN    = 2;          // Slow RC enable

  // Reset values: slow RC undivided as clock, both RC oscillators on
  localparam logic [7:0] MODE_RST      = 8'hf4;
  localparam logic [7:0] XTAL_RST      = 8'h00;
  localparam logic [7:0] TRIM_RST      = 8'h80;

  // Clock mode codes loaded by the trim step
  localparam logic [7:0] MODE_FAST_D2  = 8'h34;
  localparam logic [7:0] MODE_FAST_D4  = 8'h14;
  localparam logic [7:0] MODE_FAST_D8  = 8'h3c;
  localparam logic [7:0] MODE_FAST_D16 = 8'h1c;
  localparam logic [7:0] MODE_FAST_D32 = 8'h7c;
  localparam logic [7:0] MODE_SLOW_D1  = 8'he4;

  // Selector keys formed from mode bits [7:5] and bit 3
  localparam logic [3:0] KEY_FAST_D2   = 4'h2;
  localparam logic [3:0] KEY_FAST_D4   = 4'h0;
  localparam logic [3:0] KEY_FAST_D8   = 4'h3;
  localparam logic [3:0] KEY_FAST_D16  = 4'h1;
  localparam logic [3:0] KEY_FAST_D32  = 4'h7;
  localparam logic [3:0] KEY_SLOW_D1   = 4'he;
  localparam logic [3:0] KEY_XTAL_D1   = 4'ha;

  // Trim step divider straps
  localparam logic [2:0] TDIV_D2       = 3'h0;
  localparam logic [2:0] TDIV_D4       = 3'h1;
  localparam logic [2:0] TDIV_D8       = 3'h2;
  localparam logic [2:0] TDIV_D16      = 3'h3;
  localparam logic [2:0] TDIV_D32      = 3'h4;
  localparam logic [2:0] TDIV_SLOW     = 3'h5;

  // Trim target range in MHz
  localparam logic [4:0] TRIM_MHZ_MIN  = 5'h10;
  localparam logic [4:0] TRIM_MHZ_MAX  = 5'h12;

  // Boot wait in slow RC cycles
  localparam logic [10:0] BOOT_WAIT    = 11'h400;

  // First program address after boot
  localparam logic [9:0] PC_RESET      = 10'h000;

  // Clock sources, Gray ordered
  typedef enum logic [1:0] {
    SRC_SLOW = 2'b00,
    SRC_FAST = 2'b01,
    SRC_XTAL = 2'b11
  } osbc_src_t;

  // Boot phases
  typedef enum logic [0:0] {
    BOOT_WAIT_ST = 1'b0,
    BOOT_RUN_ST  = 1'b1
  } osbc_boot_t;

endpackage : osbc_pkg
